/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import ttcs_pkg::*;

    localparam int BURST = 20;
    localparam int EXT = 40;

    typedef struct packed
    {
        logic [3:0] first_control_register;
        logic [3:0] second_control_register;
        logic [4:0] exp;
    } ttcs_row_type;

    // Expected {osc_pd, rx_pd, progress, column, single}
    ttcs_row_type    rows [6] = '{'{4'h1, 4'h0, 5'h00}, '{4'h0, 4'h2, 5'h18},
                                  '{4'h1, 4'h6, 5'h09}, '{4'h3, 4'hc, 5'h07},
                                  '{4'h0, 4'h8, 5'h02}, '{4'h2, 4'he, 5'h1f}};
    logic            i_mclk;
    logic            i_reset;
    logic            cs_n;
    logic            rd_n;
    logic            wr_n;
    logic            rs;
    ttcs_nibble_type wdata;
    ttcs_nibble_type rdata;
    ttcs_nibble_type tx_code;
    ttcs_nibble_type digit_code;
    ttcs_nibble_type v;
    logic            digit_valid;
    logic            absence;
    logic            cp_square;
    logic            data_oe;
    logic            pin_oe;
    logic            tone_oe;
    logic            single;
    logic            column;
    logic            prog;
    logic            rx_pd;
    logic            osc_pd;
    logic            clr;
    logic            pin_out;
    int              oe_cnt;
    int              tone_cnt;
    int              gap_cnt;
    int              fails;
    int              check_count;

    ttcs_control_status #(.P_BURST_CYCLES(BURST), .P_EXT_BURST_CYCLES(EXT)) u_dut
    (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_register_select_line(rs), .i_data(wdata), .i_digit_valid(digit_valid),
        .i_digit_code(digit_code), .i_absence_valid(absence), .i_cp_square(cp_square),
        .o_data(rdata), .o_data_oe(data_oe), .o_interrupt_progress_pin_out(pin_out),
        .o_interrupt_progress_pin_oe(pin_oe), .o_tx_code(tx_code), .o_tone_pin_oe(tone_oe),
        .o_single_tone(single), .o_column_tone(column), .o_progress_mode_select(prog),
        .o_rx_power_down(rx_pd), .o_osc_power_down(osc_pd)
    );

    ttcs_host_model u_host
    (
        .i_mclk(i_mclk), .i_data(rdata), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_register_select_line(rs), .o_data(wdata)
    );

    initial
    begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // Tone length, then silent cycles until the interrupt pin pulls low
    always @(posedge i_mclk)
    begin
        if (clr)
        begin
            tone_cnt <= 0;
            gap_cnt <= 0;
        end
        else if (tone_oe === 1'b1)
            tone_cnt <= tone_cnt + 1;
        else if (tone_cnt != 0 && pin_oe !== 1'b1)
            gap_cnt <= gap_cnt + 1;
    end

    // Read drive cycles, compared per read against the strobe length
    always @(posedge i_mclk)
    begin
        if (data_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic expect_read(input logic sel, input ttcs_nibble_type exp);
        ttcs_nibble_type got;
        int              oe_before;
        oe_before = oe_cnt;
        u_host.bus_read(sel, got);
        check(8'(got), 8'(exp));
        check(8'(oe_cnt - oe_before), 8'h04);
    endtask

    task automatic set_ctrl(input ttcs_nibble_type first_control_register, input ttcs_nibble_type second_control_register);
        u_host.bus_write(1'b1, first_control_register | 4'h8);
        u_host.bus_write(1'b1, second_control_register);
    endtask

    task automatic pulse(input logic is_digit, input ttcs_nibble_type code);
        @(posedge i_mclk);
        digit_valid <= is_digit;
        absence <= ~is_digit;
        digit_code <= code;
        @(posedge i_mclk);
        digit_valid <= 1'b0;
        absence <= 1'b0;
    endtask

    task automatic clear_counters();
        @(posedge i_mclk);
        clr <= 1'b1;
        @(posedge i_mclk);
        clr <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge i_mclk);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        #1;
        check({tx_code, tone_oe, pin_oe, data_oe, osc_pd}, 8'h00);
        check({5'h0, pin_out, rx_pd, prog}, 8'h00);
    endtask

    task automatic complete_run();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_mclk);
        fails++;
        complete_run();
    end

    initial
    begin
        i_reset = 1'b1;
        digit_valid = 1'b0;
        absence = 1'b0;
        digit_code = 4'h0;
        cp_square = 1'b0;
        clr = 1'b1;
        fails = 0;
        check_count = 0;
        oe_cnt = 0;
        do_reset();
        u_host.software_reset(v);
        check(8'(v), 8'h00);
        foreach (rows[i])
        begin
            set_ctrl(rows[i].first_control_register, rows[i].second_control_register);
            #1;
            check(8'({osc_pd, rx_pd, prog, column, single}), 8'(rows[i].exp));
        end
        set_ctrl(4'h1, 4'h0);
        u_host.bus_write(1'b1, 4'h3);
        #1;
        check({6'h0, prog, rx_pd}, 8'h02);
        // Normal burst with interrupts on
        set_ctrl(4'h5, 4'h0);
        clear_counters();
        u_host.bus_write(1'b0, 4'h7);
        #1;
        check({3'h0, tx_code, tone_oe}, 8'h0f);
        repeat (3 * BURST) @(posedge i_mclk);
        check(8'(tone_cnt), 8'(BURST));
        check(8'(gap_cnt >= BURST && gap_cnt <= BURST + 2), 8'h01);
        check({7'h0, pin_oe}, 8'h01);
        expect_read(1'b1, 4'h3);
        expect_read(1'b1, 4'h0);
        // Extended burst in progress mode
        set_ctrl(4'h3, 4'h0);
        clear_counters();
        u_host.bus_write(1'b0, 4'h7);
        repeat (EXT + EXT / 2) @(posedge i_mclk);
        expect_read(1'b1, 4'h0);
        repeat (EXT) @(posedge i_mclk);
        check(8'(tone_cnt), 8'(EXT));
        expect_read(1'b1, 4'h3);
        // Non-burst tone lasts until tone output is switched off
        set_ctrl(4'h1, 4'h1);
        u_host.bus_write(1'b0, 4'h5);
        repeat (3 * EXT) @(posedge i_mclk);
        #1;
        check({3'h0, tx_code, tone_oe}, 8'h0b);
        expect_read(1'b1, 4'h0);
        u_host.bus_write(1'b1, 4'h0);
        #1;
        check({3'h0, tx_code, tone_oe}, 8'h00);
        // Receive path
        set_ctrl(4'h5, 4'h0);
        pulse(1'b1, 4'h9);
        repeat (3) @(posedge i_mclk);
        #1;
        check({7'h0, pin_oe}, 8'h01);
        expect_read(1'b1, 4'h5);
        expect_read(1'b0, 4'h9);
        pulse(1'b0, 4'h0);
        expect_read(1'b1, 4'h8);
        pulse(1'b1, 4'h2);
        expect_read(1'b1, 4'h5);
        set_ctrl(4'h6, 4'h0);
        pulse(1'b1, 4'h3);
        expect_read(1'b1, 4'h0);
        @(posedge i_mclk);
        cp_square <= 1'b1;
        repeat (5) @(posedge i_mclk);
        #1;
        check({7'h0, pin_oe}, 8'h00);
        @(posedge i_mclk);
        cp_square <= 1'b0;
        repeat (5) @(posedge i_mclk);
        #1;
        check({7'h0, pin_oe}, 8'h01);
        set_ctrl(4'h5, 4'h2);
        pulse(1'b1, 4'h4);
        expect_read(1'b1, 4'h0);
        do_reset();
        complete_run();
    end
endmodule

`default_nettype wire

/* dv/ttcs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ttcs_host_model
(
    input  wire logic                      i_mclk,
    input  wire ttcs_pkg::ttcs_nibble_type i_data,
    output var  logic                      o_cs_n,
    output var  logic                      o_rd_n,
    output var  logic                      o_wr_n,
    output var  logic                      o_register_select_line,
    output var  ttcs_pkg::ttcs_nibble_type o_data
);
    import ttcs_pkg::*;

    initial
    begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_register_select_line = 1'b0;
        o_data = 4'h0;
    end

    // Strobes held four clocks so the synchronisers see them
    task automatic bus_write(input logic rs, input ttcs_nibble_type value);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_wr_n <= 1'b0;
        o_register_select_line <= rs;
        o_data <= value;
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        // Released bus must not look like held data
        o_data <= ~value;
        repeat (4) @(posedge i_mclk);
    endtask

    task automatic bus_read(input logic rs, output ttcs_nibble_type value);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        o_register_select_line <= rs;
        repeat (4) @(posedge i_mclk);
        value = i_data;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask

    // Power-up initialisation, returns the closing status value
    task automatic software_reset(output ttcs_nibble_type status);
        bus_read(1'b1, status);
        bus_write(1'b1, 4'h0);
        bus_write(1'b1, 4'h0);
        bus_write(1'b1, 4'h8);
        bus_write(1'b1, 4'h0);
        bus_read(1'b1, status);
    endtask
endmodule

`default_nettype wire

/* verilog/ttcs_control_status.sv */
`timescale 1ns/100ps
`default_nettype none

`include "ttcs_control_status_regs.svh"

module ttcs_control_status
    import ttcs_pkg::*;
#(
    parameter int P_BURST_CYCLES     = `TTCS_BURST_US * `TTCS_CLK_MHZ,
    parameter int P_EXT_BURST_CYCLES = `TTCS_EXT_BURST_US * `TTCS_CLK_MHZ
)
(
    input  wire logic                i_mclk,
    input  wire logic                i_reset,
    input  wire logic                i_cs_n,
    input  wire logic                i_rd_n,
    input  wire logic                i_wr_n,
    input  wire logic                i_register_select_line,
    input  wire ttcs_pkg::ttcs_nibble_type i_data,
    input  wire logic                i_digit_valid,
    input  wire ttcs_pkg::ttcs_nibble_type i_digit_code,
    input  wire logic                i_absence_valid,
    input  wire logic                i_cp_square,
    output var  ttcs_pkg::ttcs_nibble_type o_data,
    output var  logic                o_data_oe,
    output var  logic                o_interrupt_progress_pin_out,
    output var  logic                o_interrupt_progress_pin_oe,
    output var  ttcs_pkg::ttcs_nibble_type o_tx_code,
    output var  logic                o_tone_pin_oe,
    output var  logic                o_single_tone,
    output var  logic                o_column_tone,
    output var  logic                o_progress_mode_select,
    output var  logic                o_rx_power_down,
    output var  logic                o_osc_power_down
);

    import ttcs_pkg::*;

    localparam int CW = 24;

    logic [7:0]           sync_vec;
    logic                 s_cs_n;
    logic                 s_rd_n;
    logic                 s_wr_n;
    logic                 s_rs;
    ttcs_nibble_type      s_data;
    logic                 s_cp;

    ttcs_sync #(.WIDTH(9)) u_sync
    (
        .i_mclk        (i_mclk),
        .i_reset       (i_reset),
        .i_async       ({i_cp_square, i_cs_n, i_rd_n, i_wr_n, i_register_select_line, i_data}),
        .i_reset_value (9'h0e0),
        .o_sync        ({s_cp, sync_vec})
    );

    assign {s_cs_n, s_rd_n, s_wr_n, s_rs, s_data} = sync_vec;

    ttcs_nibble_type      cra_reg, cra_next;
    ttcs_nibble_type      crb_reg, crb_next;
    logic                 second_pending_reg, second_pending_next;
    ttcs_nibble_type      tx_code_reg, tx_code_next;
    ttcs_nibble_type      rx_code_reg, rx_code_next;
    logic                 irq_st_reg, irq_st_next;
    logic                 txe_reg, txe_next;
    logic                 rxf_reg, rxf_next;
    logic                 dsteer_reg, dsteer_next;
    logic                 wr_act_reg, wr_act_next;
    logic                 wr_rs_reg, wr_rs_next;
    ttcs_nibble_type      wr_data_reg, wr_data_next;
    logic                 rd_act_reg, rd_act_next;
    logic                 rd_rs_reg, rd_rs_next;
    ttcs_burst_state_type state_reg, state_next;
    logic [CW-1:0]        cnt_reg, cnt_next;
    ttcs_nibble_type      o_data_next;
    logic                 oe_next, irq_oe_next, tone_oe_next;
    logic                 single_next, column_next, mode_next, rxpd_next, oscpd_next;

    logic                 wr_act, wr_done, rd_act, rd_start, rd_done;
    logic                 ctrl_wr, tx_wr, st_rd_done;
    logic                 burst_mode, tone_on, ev_txe, ev_rxf, cnt_last;
    logic [CW-1:0]        dur_last;

    always_comb
    begin
        wr_act     = ~s_cs_n & ~s_wr_n;
        rd_act     = ~s_cs_n & ~s_rd_n;
        wr_done    = wr_act_reg & ~wr_act;
        rd_start   = rd_act & ~rd_act_reg;
        rd_done    = rd_act_reg & ~rd_act;
        ctrl_wr    = wr_done & (wr_rs_reg == `TTCS_RS_CONTROL);
        tx_wr      = wr_done & (wr_rs_reg == `TTCS_RS_DATA);
        st_rd_done = rd_done & (rd_rs_reg == `TTCS_RS_CONTROL);
        burst_mode = ~crb_reg[`TTCS_CRB_BURST_N];
        tone_on    = cra_reg[`TTCS_CRA_TONE_OUT];
        // Duration follows the mode live, so a mode change mid burst stretches or shortens it
        dur_last   = cra_reg[`TTCS_CRA_PROGRESS] ? CW'(P_EXT_BURST_CYCLES - 1)
                                                 : CW'(P_BURST_CYCLES - 1);
        cnt_last   = (cnt_reg >= dur_last);
        ev_txe     = (state_reg == TTCS_PAUSE) & cnt_last & burst_mode & tone_on;
        // Digits are ignored while receivers are down or in call-progress mode
        ev_rxf     = i_digit_valid & ~crb_reg[`TTCS_CRB_RX_PD]
                     & ~cra_reg[`TTCS_CRA_PROGRESS];
    end

    always_comb
    begin
        cra_next            = cra_reg;
        crb_next            = crb_reg;
        second_pending_next = second_pending_reg;
        tx_code_next        = tx_code_reg;
        rx_code_next        = rx_code_reg;
        wr_act_next         = wr_act;
        wr_rs_next          = wr_act ? s_rs : wr_rs_reg;
        wr_data_next        = wr_act ? s_data : wr_data_reg;
        rd_act_next         = rd_act;
        rd_rs_next          = rd_start ? s_rs : rd_rs_reg;
        state_next          = state_reg;
        cnt_next            = cnt_reg;

        if (ctrl_wr)
        begin
            if (second_pending_reg)
            begin
                crb_next            = wr_data_reg;
                second_pending_next = 1'b0;
            end
            else
            begin
                cra_next            = wr_data_reg;
                second_pending_next = wr_data_reg[`TTCS_CRA_SECOND_SEL];
            end
        end

        if (tx_wr)
        begin
            tx_code_next = wr_data_reg;
        end

        case (state_reg)
            TTCS_IDLE:
            begin
                cnt_next = '0;
                if (tx_wr & burst_mode & tone_on)
                begin
                    state_next = TTCS_TONE;
                end
            end
            TTCS_TONE:
            begin
                cnt_next = cnt_reg + CW'(1);
                if (cnt_last)
                begin
                    state_next = TTCS_PAUSE;
                    cnt_next   = '0;
                end
            end
            TTCS_PAUSE:
            begin
                cnt_next = cnt_reg + CW'(1);
                if (cnt_last)
                begin
                    state_next = TTCS_IDLE;
                    cnt_next   = '0;
                end
            end
            default:
            begin
                state_next = TTCS_IDLE;
                cnt_next   = '0;
            end
        endcase

        // Leaving burst mode or tone output aborts any burst in flight
        if (~burst_mode | ~tone_on)
        begin
            state_next = TTCS_IDLE;
            cnt_next   = '0;
        end

        if (~tone_on)
        begin
            tx_code_next = `TTCS_NIBBLE_RESET;
        end

        if (ev_rxf)
        begin
            rx_code_next = i_digit_code;
        end

        // Hardware set wins over the read clear in the same cycle
        txe_next    = ev_txe | (txe_reg & ~st_rd_done & burst_mode);
        rxf_next    = ev_rxf | (rxf_reg & ~st_rd_done);
        irq_st_next = ev_txe | ev_rxf | (irq_st_reg & ~st_rd_done);
        dsteer_next = i_absence_valid ? 1'b1 : (i_digit_valid ? 1'b0 : dsteer_reg);

        // Snapshot taken at read start holds pre-clear flags for the whole read
        o_data_next = o_data;
        if (rd_start)
        begin
            o_data_next = (s_rs == `TTCS_RS_CONTROL)
                          ? {dsteer_reg, rxf_reg, txe_reg, irq_st_reg}
                          : rx_code_reg;
        end
        oe_next = rd_act;

        if (cra_reg[`TTCS_CRA_IRQ_EN] & cra_reg[`TTCS_CRA_PROGRESS])
        begin
            irq_oe_next = ~s_cp;
        end
        else
        begin
            irq_oe_next = cra_reg[`TTCS_CRA_IRQ_EN] & irq_st_reg;
        end

        tone_oe_next = tone_on & (~burst_mode | (state_next == TTCS_TONE));
        single_next  = crb_reg[`TTCS_CRB_SINGLE];
        column_next  = crb_reg[`TTCS_CRB_COLUMN];
        mode_next    = cra_reg[`TTCS_CRA_PROGRESS];
        rxpd_next    = crb_reg[`TTCS_CRB_RX_PD];
        oscpd_next   = ~tone_on & crb_reg[`TTCS_CRB_RX_PD];
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cra_reg                      <= `TTCS_NIBBLE_RESET;
            crb_reg                      <= `TTCS_NIBBLE_RESET;
            second_pending_reg           <= 1'b0;
            tx_code_reg                  <= `TTCS_NIBBLE_RESET;
            rx_code_reg                  <= `TTCS_NIBBLE_RESET;
            irq_st_reg                   <= 1'b0;
            txe_reg                      <= 1'b0;
            rxf_reg                      <= 1'b0;
            dsteer_reg                   <= 1'b0;
            wr_act_reg                   <= 1'b0;
            wr_rs_reg                    <= 1'b0;
            wr_data_reg                  <= `TTCS_NIBBLE_RESET;
            rd_act_reg                   <= 1'b0;
            rd_rs_reg                    <= 1'b0;
            state_reg                    <= TTCS_IDLE;
            cnt_reg                      <= '0;
            o_data                       <= `TTCS_NIBBLE_RESET;
            o_data_oe                    <= 1'b0;
            o_interrupt_progress_pin_oe  <= 1'b0;
            o_tone_pin_oe                <= 1'b0;
            o_single_tone                <= 1'b0;
            o_column_tone                <= 1'b0;
            o_progress_mode_select       <= 1'b0;
            o_rx_power_down              <= 1'b0;
            o_osc_power_down             <= 1'b0;
        end
        else
        begin
            cra_reg                      <= cra_next;
            crb_reg                      <= crb_next;
            second_pending_reg           <= second_pending_next;
            tx_code_reg                  <= tx_code_next;
            rx_code_reg                  <= rx_code_next;
            irq_st_reg                   <= irq_st_next;
            txe_reg                      <= txe_next;
            rxf_reg                      <= rxf_next;
            dsteer_reg                   <= dsteer_next;
            wr_act_reg                   <= wr_act_next;
            wr_rs_reg                    <= wr_rs_next;
            wr_data_reg                  <= wr_data_next;
            rd_act_reg                   <= rd_act_next;
            rd_rs_reg                    <= rd_rs_next;
            state_reg                    <= state_next;
            cnt_reg                      <= cnt_next;
            o_data                       <= o_data_next;
            o_data_oe                    <= oe_next;
            o_interrupt_progress_pin_oe  <= irq_oe_next;
            o_tone_pin_oe                <= tone_oe_next;
            o_single_tone                <= single_next;
            o_column_tone                <= column_next;
            o_progress_mode_select       <= mode_next;
            o_rx_power_down              <= rxpd_next;
            o_osc_power_down             <= oscpd_next;
        end
    end

    // Open-drain pin only ever pulls low
    always_ff @(posedge i_mclk)
    begin
        o_interrupt_progress_pin_out <= 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        o_tx_code <= i_reset ? `TTCS_NIBBLE_RESET : tx_code_next;
    end

    // Cycles since the last transmit write, for the minimum spacing check
    logic [CW:0] since_wr_reg;
    always_ff @(posedge i_mclk)
    begin
        if (i_reset | tx_wr)
        begin
            since_wr_reg <= '0;
        end
        else if (~&since_wr_reg)
        begin
            since_wr_reg <= since_wr_reg + (CW+1)'(1);
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    sequence seq_second_write;
        ctrl_wr && second_pending_reg;
    endsequence

    sequence seq_burst_start;
        tx_wr && burst_mode && tone_on && (state_reg == TTCS_IDLE);
    endsequence

    burst_start_a: assert property (seq_burst_start |=> state_reg == TTCS_TONE)
        else $error("burst did not start after transmit write");
    txe_cause_a: assert property ($rose(txe_reg) |-> $past(state_reg) == TTCS_PAUSE)
        else $error("transmit empty set outside pause end");
    txe_nonburst_a: assert property (!burst_mode |=> !txe_reg)
        else $error("transmit empty held in non-burst mode");
    burst_spacing_a: assert property ($rose(txe_reg) |->
        since_wr_reg >= (CW+1)'(2 * P_BURST_CYCLES))
        else $error("transmit empty came too early");
    irq_clear_a: assert property (st_rd_done && !ev_txe && !ev_rxf |=> !irq_st_reg)
        else $error("interrupt status not cleared by read");
    rxf_set_a: assert property (ev_rxf |=> rxf_reg && rx_code_reg == $past(i_digit_code))
        else $error("receive full or digit not captured");
    second_route_a: assert property (seq_second_write |=>
        !second_pending_reg && crb_reg == $past(wr_data_reg) ##1 !second_pending_reg)
        else $error("second control write misrouted");
    osc_down_a: assert property (o_osc_power_down |-> $past(!tone_on && rxpd_next))
        else $error("oscillator down without both sections down");
    tone_clear_a: assert property (!tone_on |=> tx_code_reg == '0 && !o_tone_pin_oe)
        else $error("tone output off did not clear transmitter");
    irq_pin_a: assert property (cra_reg[`TTCS_CRA_IRQ_EN] && irq_st_reg
        && !cra_reg[`TTCS_CRA_PROGRESS] |=> o_interrupt_progress_pin_oe)
        else $error("interrupt pin not pulled low");
    read_snap_a: assert property (rd_start && s_rs |=>
        o_data[`TTCS_ST_TX_EMPTY] == $past(txe_reg))
        else $error("status read did not return pre-read flags");

endmodule

`default_nettype wire

/* verilog/ttcs_control_status_regs.svh */
`ifndef TTCS_CONTROL_STATUS_REGS_SVH
`define TTCS_CONTROL_STATUS_REGS_SVH

// Register-select line values
`define TTCS_RS_DATA        1'b0
`define TTCS_RS_CONTROL     1'b1

// First control register fields
`define TTCS_CRA_TONE_OUT   0
`define TTCS_CRA_PROGRESS   1
`define TTCS_CRA_IRQ_EN     2
`define TTCS_CRA_SECOND_SEL 3

// Second control register fields
`define TTCS_CRB_BURST_N    0
`define TTCS_CRB_RX_PD      1
`define TTCS_CRB_SINGLE     2
`define TTCS_CRB_COLUMN     3

// Status register fields
`define TTCS_ST_IRQ         0
`define TTCS_ST_TX_EMPTY    1
`define TTCS_ST_RX_FULL     2
`define TTCS_ST_DSTEER      3

`define TTCS_NIBBLE_RESET   4'h0

// Timing
`define TTCS_CLK_MHZ        50
`define TTCS_BURST_US       51000
`define TTCS_EXT_BURST_US   102000
`define TTCS_SYNC_STAGES    2

`endif

/* verilog/ttcs_pkg.sv */
`default_nettype none

package ttcs_pkg;

    typedef logic [3:0] ttcs_nibble_type;

    typedef enum logic [2:0]
    {
        TTCS_IDLE  = 3'b001,
        TTCS_TONE  = 3'b010,
        TTCS_PAUSE = 3'b100
    } ttcs_burst_state_type;

endpackage

`default_nettype wire

/* verilog/ttcs_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module ttcs_sync
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    input  wire logic [WIDTH-1:0] i_reset_value,
    output var  logic [WIDTH-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge i_mclk)
            begin
                if (i_reset)
                begin
                    meta_reg <= i_reset_value[g];
                    sync_reg <= i_reset_value[g];
                end
                else
                begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            // Flops rest at the idle level, so no false strobe follows reset
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule

`default_nettype wire
